//--- hw/touch_led_pkg.sv
// Constants, register map and carriers for the touch LED output logic.
// Assumes a 100 MHz system clock and a 32-bit register bus.
package touch_led_pkg;
  localparam int CLK_PERIOD_NS      = 10;
  localparam int TICK_MS            = 10;
  localparam int TICK_CYCLES_DEF    = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int HOLD_STEP_MS       = 20;
  localparam int HOLD_STEP_TICKS    = HOLD_STEP_MS / TICK_MS;
  localparam int AUTO_RST_SHORT_MS  = 5000;
  localparam int AUTO_RST_LONG_MS   = 20000;
  localparam int AUTO_RST_SHORT_TK  = AUTO_RST_SHORT_MS / TICK_MS;
  localparam int AUTO_RST_LONG_TK   = AUTO_RST_LONG_MS / TICK_MS;
  localparam int INIT_NORMAL_MS     = 350;
  localparam int INIT_HIGH_MS       = 1000;
  localparam int INIT_NORMAL_TK     = INIT_NORMAL_MS / TICK_MS;
  localparam int INIT_HIGH_TK       = INIT_HIGH_MS / TICK_MS;
  localparam logic [7:0] THR_MIN    = 8'h32;
  localparam logic [7:0] THR_MAX    = 8'hF5;
  localparam logic [7:0] THR_RST    = 8'h64;
  localparam logic [6:0] PWM_STEPS  = 7'h64;
  localparam logic [6:0] DUTY_FULL  = 7'h64;
  localparam logic [6:0] STBY_20    = 7'h14;
  localparam logic [6:0] STBY_30    = 7'h1E;
  localparam logic [6:0] STBY_50    = 7'h32;
  localparam logic [3:0] IDX_CTRL   = 4'h0;
  localparam logic [3:0] IDX_THR    = 4'h1;
  localparam logic [3:0] IDX_SUPP   = 4'h2;
  localparam logic [3:0] IDX_TOGGLE = 4'h3;
  localparam logic [3:0] IDX_EFFECT = 4'h4;
  localparam logic [3:0] IDX_HOLD   = 4'h5;
  localparam logic [3:0] IDX_STATUS = 4'h6;
  localparam int POWERON_BIT        = 16;

  typedef struct packed {
    logic [1:0] standby;
    logic       autoRst20;
    logic       autoRstEn;
    logic       seqPowerOn;
    logic       breathing;
    logic       lastTouch;
    logic       autoThr;
    logic       noiseHigh;
  } ctrl_s;

  localparam ctrl_s CTRL_RST = 9'h000;

  typedef struct packed {
    logic [7:0] rep;
    logic [6:0] hi;
    logic [6:0] lo;
    logic [7:0] tDown;
    logic [7:0] tHigh;
    logic [7:0] tUp;
    logic [7:0] tLow;
  } effect_param_s;
endpackage

//--- hw/led_effect.sv
// One LED effect sequencer: ramp up, high, ramp down, low, repeats.
// Assumes a one-cycle time-unit tick and parameters held stable.
`timescale 1ns/100ps
module led_effect (
  input  wire logic                         clk_sys,
  input  wire logic                         reset,
  input  wire logic                         clkEn,
  input  wire logic                         tick,
  input  wire logic                         start,
  input  wire logic                         stop,
  input  wire logic                         held,
  input  wire logic                         breathing,
  input  wire touch_led_pkg::effect_param_s prm,
  output logic [6:0]                        duty,
  output logic                              active
);
  typedef enum {PH_IDLE, PH_UP, PH_HIGH, PH_DOWN, PH_LOW} phase_e;
  phase_e     phase_reg, phase_next;
  logic [7:0] timer_reg, timer_next, rep_reg, rep_next, dur, den;
  logic [14:0] prod;
  logic [6:0]  diff, rampStep;
  logic        expire;

  always_comb begin
    case (phase_reg)
      PH_UP:   dur = prm.tUp;
      PH_HIGH: dur = prm.tHigh;
      PH_DOWN: dur = prm.tDown;
      PH_LOW:  dur = prm.tLow;
      default: dur = 8'h00;
    endcase
  end

  assign expire   = timer_reg >= dur;
  assign den      = (dur == 8'h00) ? 8'h01 : dur;
  // High above low is the configuring side's duty; no signed path here
  assign diff     = 7'(prm.hi - prm.lo);
  assign prod     = 15'(diff) * 15'(timer_reg);
  assign rampStep = 7'(prod / 15'(den));

  always_comb begin
    phase_next = phase_reg;
    timer_next = (tick && !expire) ? 8'(timer_reg + 8'h01) : timer_reg;
    rep_next   = rep_reg;
    if (stop) begin
      phase_next = PH_IDLE;
      timer_next = 8'h00;
    end else if (start) begin
      phase_next = PH_UP;
      timer_next = 8'h00;
      rep_next   = prm.rep;
    end else begin
      case (phase_reg)
        PH_UP: if (expire) begin
          phase_next = PH_HIGH;
          timer_next = 8'h00;
        end
        PH_HIGH: if (!breathing && held) begin
          timer_next = 8'h00;
        end else if (expire) begin
          phase_next = PH_DOWN;
          timer_next = 8'h00;
        end
        PH_DOWN: if (expire) begin
          phase_next = PH_LOW;
          timer_next = 8'h00;
        end
        PH_LOW: if (expire) begin
          timer_next = 8'h00;
          if (breathing && held) begin
            phase_next = PH_UP;
          end else if (rep_reg != 8'h00) begin
            phase_next = PH_UP;
            rep_next   = 8'(rep_reg - 8'h01);
          end else begin
            phase_next = PH_IDLE;
          end
        end
        default: phase_next = PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      phase_reg <= PH_IDLE;
      timer_reg <= 8'h00;
      rep_reg   <= 8'h00;
    end else if (clkEn) begin
      phase_reg <= phase_next;
      timer_reg <= timer_next;
      rep_reg   <= rep_next;
    end
  end

  always_comb begin
    case (phase_reg)
      PH_UP:   duty = 7'(prm.lo + rampStep);
      PH_HIGH: duty = prm.hi;
      PH_DOWN: duty = 7'(prm.hi - rampStep);
      PH_LOW:  duty = prm.lo;
      default: duty = 7'h00;
    endcase
  end

  assign active = phase_reg != PH_IDLE;
endmodule // led_effect

//--- hw/touch_led_out.sv
// Touch-decision post-processing driving ten active-low LED outputs.
// Assumes button counts synchronous to clk_sys, Avalon-MM master on bus.
// Functional notes
// - Suppression lets one enabled button be touched
// - High noise immunity needs longer agreement
// - Threshold 50 to 245, or automatic
// - Hold output low after release, 20ms steps
// - Hold timer follows last released button only
// - No hold after auto reset release
// - No hold with toggle or effects
// - Auto reset after 5 or 20 seconds
// - Effect parameters shared per output group
// - Buttons disabled during power-on effects
// - Effect levels, four phase times, repeat count
// - Power-on effects after init time
// - Power-on pattern sequential or concurrent
// - Writes dropped during power-on effects
// - Breathing cycles while touched, then repeats
// - Non-breathing holds high while touched
// - Re-touch restarts the pattern
// - Toggle with effects alternates standby/high
// - Deep sleep stops touch effects at once
// - Last-touch mode moves effect to newest
// - Last-touch mode skips toggle buttons
// - Outputs active low, follow their buttons
// - Toggle mode inverts output per touch
// - Standby brightness 0, 20, 30 or 50%
`timescale 1ns/100ps
module touch_led_out #(
  parameter int                    NB          = 10,
  parameter int                    TICK_CYCLES = touch_led_pkg::TICK_CYCLES_DEF,
  parameter touch_led_pkg::ctrl_s CTRL_INIT   = touch_led_pkg::CTRL_RST
) (
  input  wire logic                clk_sys,
  input  wire logic                reset,
  input  wire logic                clkEn,
  input  wire logic [5:0]          address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [31:0]         writedata,
  output logic      [31:0]         readdata,
  output logic                     waitrequest,
  input  wire logic [NB-1:0][7:0]  buttonSignal,
  input  wire logic [7:0]          autoThreshold,
  input  wire logic [NB-1:0]       selfTestFail,
  input  wire logic                deepSleep,
  output logic      [NB-1:0]       ledOutput_n,
  output logic                     powerOnBusy
);
  localparam int TCW = $clog2(TICK_CYCLES + 1);
  typedef enum {PO_INIT, PO_KICK, PO_WAIT, PO_RUN} po_e;

  touch_led_pkg::ctrl_s         ctrl_reg;
  touch_led_pkg::effect_param_s prm_reg [4];
  logic [7:0]      thr_reg, hold_reg;
  logic [NB-1:0]   supEn_reg, togEn_reg, effEn_reg;
  logic [TCW-1:0]  tickCnt_reg;
  logic            tick_reg;
  po_e             poState_reg;
  logic [6:0]      poCnt_reg, pwmCnt_reg;
  logic [3:0]      poIdx_reg, owner_reg, owner_next, holdIdx_reg;
  logic            ownerOk_reg, ownerOk_next, holdOn_reg;
  logic [NB-1:0]   h0_reg, h1_reg, h2_reg, arDone_reg, touched_reg;
  logic [NB-1:0]   togState_reg, touched_next, rise, fall, holdEl;
  logic [10:0]     arCnt_reg [NB];
  logic [8:0]      holdCnt_reg;
  logic [NB-1:0]   raw, sensed, live, effStart, effStop, effActive, poStart;
  logic [6:0]      effDuty [NB];
  logic [6:0]      dutyOut [NB];
  logic [3:0]      holdPick;
  logic            holdAny;

  // Bus decode and read mux
  wire        poRun    = poState_reg == PO_RUN;
  wire [3:0]  regIdx   = address[5:2];
  wire        selPrm   = address[5];
  wire [1:0]  prmSet   = address[4:3];
  wire        wrStrobe = write && !waitrequest && poRun;
  wire [31:0] stsWord  = {15'h0000, !poRun, 6'h00, touched_reg};
  wire [31:0] prmA     = {8'h00, prm_reg[prmSet].rep, 1'b0,
                          prm_reg[prmSet].hi, 1'b0, prm_reg[prmSet].lo};
  wire [31:0] prmB     = {prm_reg[prmSet].tDown, prm_reg[prmSet].tHigh,
                          prm_reg[prmSet].tUp, prm_reg[prmSet].tLow};
  wire [31:0] rdMux    =
    selPrm ? (address[2] ? prmB : prmA) :
    (regIdx == touch_led_pkg::IDX_CTRL)   ? 32'(ctrl_reg)  :
    (regIdx == touch_led_pkg::IDX_THR)    ? 32'(thr_reg)   :
    (regIdx == touch_led_pkg::IDX_SUPP)   ? 32'(supEn_reg) :
    (regIdx == touch_led_pkg::IDX_TOGGLE) ? 32'(togEn_reg) :
    (regIdx == touch_led_pkg::IDX_EFFECT) ? 32'(effEn_reg) :
    (regIdx == touch_led_pkg::IDX_HOLD)   ? 32'(hold_reg)  :
    (regIdx == touch_led_pkg::IDX_STATUS) ? stsWord : 32'h0000_0000;

  // One wait state; answer lands on the second edge of a request
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else if (clkEn) begin
      waitrequest <= !((read || write) && waitrequest);
      if ((read || write) && waitrequest) readdata <= rdMux;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_reg  <= CTRL_INIT;
      thr_reg   <= touch_led_pkg::THR_RST;
      hold_reg  <= 8'h00;
      supEn_reg <= '0;
      togEn_reg <= '0;
      effEn_reg <= '0;
      for (int s = 0; s < 4; s++) prm_reg[s] <= '0;
    end else if (clkEn && wrStrobe) begin
      if (selPrm && address[2]) begin
        prm_reg[prmSet].tLow  <= writedata[7:0];
        prm_reg[prmSet].tUp   <= writedata[15:8];
        prm_reg[prmSet].tHigh <= writedata[23:16];
        prm_reg[prmSet].tDown <= writedata[31:24];
      end else if (selPrm) begin
        prm_reg[prmSet].lo  <= writedata[6:0];
        prm_reg[prmSet].hi  <= writedata[14:8];
        prm_reg[prmSet].rep <= writedata[23:16];
      end else begin
        case (regIdx)
          touch_led_pkg::IDX_CTRL:   ctrl_reg  <= writedata[8:0];
          touch_led_pkg::IDX_THR:    thr_reg   <= writedata[7:0];
          touch_led_pkg::IDX_SUPP:   supEn_reg <= writedata[NB-1:0];
          touch_led_pkg::IDX_TOGGLE: togEn_reg <= writedata[NB-1:0];
          touch_led_pkg::IDX_EFFECT: effEn_reg <= writedata[NB-1:0];
          touch_led_pkg::IDX_HOLD:   hold_reg  <= writedata[7:0];
          default: ;
        endcase
      end
    end
  end

  // Time-unit tick shared by every timer
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tickCnt_reg <= '0;
      tick_reg    <= 1'b0;
    end else if (clkEn) begin
      tick_reg    <= tickCnt_reg == TCW'(TICK_CYCLES - 1);
      tickCnt_reg <= (tickCnt_reg == TCW'(TICK_CYCLES - 1)) ? '0
                     : TCW'(tickCnt_reg + 1'b1);
    end
  end

  // Threshold clamped into its legal span
  wire [7:0] thrClamp = (thr_reg < touch_led_pkg::THR_MIN)
    ? touch_led_pkg::THR_MIN : (thr_reg > touch_led_pkg::THR_MAX)
    ? touch_led_pkg::THR_MAX : thr_reg;
  wire [7:0] thrEff = ctrl_reg.autoThr ? autoThreshold : thrClamp;
  wire [10:0] arLimit = ctrl_reg.autoRst20
    ? 11'(touch_led_pkg::AUTO_RST_LONG_TK)
    : 11'(touch_led_pkg::AUTO_RST_SHORT_TK);

  always_comb begin
    for (int i = 0; i < NB; i++) raw[i] = buttonSignal[i] >= thrEff;
  end
  // Three agreeing samples in high immunity: slower but steadier
  assign sensed = ctrl_reg.noiseHigh ? (h0_reg & h1_reg & h2_reg)
                                     : h0_reg;
  assign live   = sensed & ~arDone_reg & {NB{poRun}};

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      h0_reg     <= '0;
      h1_reg     <= '0;
      h2_reg     <= '0;
      arDone_reg <= '0;
      for (int i = 0; i < NB; i++) arCnt_reg[i] <= 11'h000;
    end else if (clkEn && tick_reg) begin
      h0_reg <= raw;
      h1_reg <= h0_reg;
      h2_reg <= h1_reg;
      for (int i = 0; i < NB; i++) begin
        if (!sensed[i]) begin
          arCnt_reg[i]  <= 11'h000;
          arDone_reg[i] <= 1'b0;
        end else if (ctrl_reg.autoRstEn && !arDone_reg[i]) begin
          if (arCnt_reg[i] >= 11'(arLimit - 11'h001))
            arDone_reg[i] <= 1'b1;
          else
            arCnt_reg[i] <= 11'(arCnt_reg[i] + 11'h001);
        end
      end
    end
  end

  // First suppressed button to touch keeps ownership
  always_comb begin
    owner_next   = owner_reg;
    ownerOk_next = ownerOk_reg && live[owner_reg] && supEn_reg[owner_reg];
    for (int i = NB - 1; i >= 0; i--) begin
      if (!ownerOk_next && live[i] && supEn_reg[i]) begin
        owner_next   = 4'(i);
        ownerOk_next = 1'b1;
      end
    end
    for (int i = 0; i < NB; i++)
      touched_next[i] = live[i] && (!supEn_reg[i] ||
                        (ownerOk_next && owner_next == 4'(i)));
  end

  assign rise   = touched_next & ~touched_reg;
  assign fall   = touched_reg & ~touched_next;
  assign holdEl = fall & ~arDone_reg & ~togEn_reg & ~effEn_reg;
  always_comb begin
    holdAny  = |holdEl;
    holdPick = 4'h0;
    for (int i = 0; i < NB; i++) if (holdEl[i]) holdPick = 4'(i);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      owner_reg    <= 4'h0;
      ownerOk_reg  <= 1'b0;
      touched_reg  <= '0;
      togState_reg <= '0;
      holdOn_reg   <= 1'b0;
      holdIdx_reg  <= 4'h0;
      holdCnt_reg  <= 9'h000;
    end else if (clkEn) begin
      owner_reg    <= owner_next;
      ownerOk_reg  <= ownerOk_next;
      touched_reg  <= touched_next;
      togState_reg <= togState_reg ^ (rise & togEn_reg);
      if (holdAny) begin
        holdIdx_reg <= holdPick;
        holdCnt_reg <= 9'(hold_reg) * 9'(touch_led_pkg::HOLD_STEP_TICKS);
        holdOn_reg  <= hold_reg != 8'h00;
      end else if (tick_reg && holdOn_reg) begin
        holdCnt_reg <= 9'(holdCnt_reg - 9'h001);
        holdOn_reg  <= holdCnt_reg > 9'h001;
      end
    end
  end

  // Power-on sequencer
  wire [6:0] initTk = ctrl_reg.noiseHigh
    ? 7'(touch_led_pkg::INIT_HIGH_TK) : 7'(touch_led_pkg::INIT_NORMAL_TK);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      poState_reg <= PO_INIT;
      poCnt_reg   <= 7'h00;
      poIdx_reg   <= 4'h0;
    end else if (clkEn) begin
      case (poState_reg)
        PO_INIT: if (poCnt_reg >= initTk) poState_reg <= PO_KICK;
          else if (tick_reg) poCnt_reg <= 7'(poCnt_reg + 7'h01);
        PO_KICK: poState_reg <= PO_WAIT;
        PO_WAIT: if (effActive == '0) begin
          if (ctrl_reg.seqPowerOn && poIdx_reg != 4'(NB - 1)) begin
            poIdx_reg   <= 4'(poIdx_reg + 4'h1);
            poState_reg <= PO_KICK;
          end else poState_reg <= PO_RUN;
        end
        PO_RUN:  poState_reg <= PO_RUN;
        default: poState_reg <= PO_INIT;
      endcase
    end
  end

  wire       touchMode = |(rise & effEn_reg & ~togEn_reg);
  wire [6:0] stbLvl =
    deepSleep ? 7'h00 :
    (ctrl_reg.standby == 2'd1) ? touch_led_pkg::STBY_20 :
    (ctrl_reg.standby == 2'd2) ? touch_led_pkg::STBY_30 :
    (ctrl_reg.standby == 2'd3) ? touch_led_pkg::STBY_50 : 7'h00;
  always_comb begin
    for (int i = 0; i < NB; i++)
      poStart[i] = poState_reg == PO_KICK &&
                   (!ctrl_reg.seqPowerOn || poIdx_reg == 4'(i));
  end
  assign effStart = (rise & effEn_reg & ~togEn_reg) | poStart;
  assign effStop  = {NB{deepSleep}} | ({NB{ctrl_reg.lastTouch &&
                    touchMode}} & ~rise & ~togEn_reg);

  for (genvar g = 0; g < NB; g++) begin : gen_out
    localparam int GRP = (g == 0) ? 0 : (g - 1) / 3 + 1;
    led_effect u_effect (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .clkEn     (clkEn),
      .tick      (tick_reg),
      .start     (effStart[g]),
      .stop      (effStop[g]),
      .held      (touched_reg[g]),
      .breathing (ctrl_reg.breathing),
      .prm       (prm_reg[GRP]),
      .duty      (effDuty[g]),
      .active    (effActive[g])
    );
    wire plainOn = togEn_reg[g] ? togState_reg[g] : (touched_reg[g] ||
                   (holdOn_reg && holdIdx_reg == 4'(g)));
    assign dutyOut[g] =
      !poRun ? (selfTestFail[g] ? 7'h00 : effDuty[g]) :
      !effEn_reg[g] ? (plainOn ? touch_led_pkg::DUTY_FULL : 7'h00) :
      togEn_reg[g] ? (togState_reg[g] ? prm_reg[GRP].hi : stbLvl) :
      effActive[g] ? effDuty[g] : stbLvl;
  end

  // PWM; outputs pulled low while lit
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pwmCnt_reg  <= 7'h00;
      ledOutput_n <= '1;
      powerOnBusy <= 1'b1;
    end else if (clkEn) begin
      pwmCnt_reg  <= (pwmCnt_reg == 7'(touch_led_pkg::PWM_STEPS - 7'h01))
                     ? 7'h00 : 7'(pwmCnt_reg + 7'h01);
      powerOnBusy <= !poRun;
      for (int i = 0; i < NB; i++)
        ledOutput_n[i] <= !(pwmCnt_reg < dutyOut[i]);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_supp_one;
    $onehot0(touched_reg & supEn_reg);
  endproperty
  a_supp_one: assert property (p_supp_one)
    else $error("two suppressed buttons touched");
  property p_po_off;
    !poRun |-> touched_reg == '0;
  endproperty
  a_po_off: assert property (p_po_off)
    else $error("button live during power-on");
  property p_wr_drop;
    clkEn && write && !waitrequest && !poRun |=> $stable(thr_reg)
      && $stable(ctrl_reg) && $stable(hold_reg);
  endproperty
  a_wr_drop: assert property (p_wr_drop)
    else $error("write taken during power-on");
  property p_thr_span;
    !ctrl_reg.autoThr |-> thrEff >= 8'h32 && thrEff <= 8'hF5;
  endproperty
  a_thr_span: assert property (p_thr_span)
    else $error("threshold outside span");
  property p_hold_load;
    clkEn && holdAny |=> holdCnt_reg == 9'($past(hold_reg)) * 9'd2
      && holdIdx_reg == $past(holdPick);
  endproperty
  a_hold_load: assert property (p_hold_load)
    else $error("hold timer not loaded");
  property p_plain_follow;
    clkEn && poRun && touched_reg[0] && !effEn_reg[0] && !togEn_reg[0]
      |=> !ledOutput_n[0];
  endproperty
  a_plain_follow: assert property (p_plain_follow)
    else $error("touched output not low");
  property p_deep_stop;
    clkEn && deepSleep && poRun |=> effActive == '0;
  endproperty
  a_deep_stop: assert property (p_deep_stop)
    else $error("effect runs in deep sleep");
  property p_toggle;
    clkEn && rise[0] && togEn_reg[0] |=> togState_reg[0] !=
      $past(togState_reg[0]);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle did not invert");
  property p_autorst;
    clkEn && tick_reg && sensed[0] && ctrl_reg.autoRstEn && !arDone_reg[0]
      && arCnt_reg[0] == 11'(arLimit - 11'h001) |=> arDone_reg[0];
  endproperty
  a_autorst: assert property (p_autorst)
    else $error("auto reset missed");
  property p_bus_answer;
    clkEn && (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer late");

  c_po_done:   cover property (poState_reg == PO_WAIT ##1 poRun);
  c_hold:      cover property (holdOn_reg ##1 !holdOn_reg);
  c_last_stop: cover property (ctrl_reg.lastTouch && touchMode
                               && |effActive);
  c_supp:      cover property (|(live & supEn_reg & ~touched_next));
endmodule // touch_led_out

//--- sim/touch_pad_model.sv
// Button pads as seen by the sensing front end: per-button counts.
// Assumes the bench sets touchMask and touchLevel off the sampling edge.
`timescale 1ns/100ps
module touch_pad_model (
  input  wire logic [9:0]      touchMask,
  input  wire logic [7:0]      touchLevel,
  output logic      [9:0][7:0] buttonSignal,
  output logic      [7:0]      autoThreshold,
  output logic      [9:0]      selfTestFail
);
  // Untouched pads sit well below any legal threshold
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      buttonSignal[i] = touchMask[i] ? touchLevel : 8'h05;
    end
  end
  assign autoThreshold = 8'hC8;
  assign selfTestFail  = 10'h000;
endmodule // touch_pad_model

//--- sim/test_touch_led_out.sv
// Self-checking bench for the touch LED output logic.
// Assumes a short tick (TICK_CYCLES = 4) so all timers stay brief.
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin checks_done++; if ((got) !== (exp)) begin \
  n_errors++; $display("[FAIL] %0t %s", $time, msg); end end
module test_touch_led_out;
  logic             clk_sys;
  logic             reset;
  logic [5:0]       address;
  logic             read;
  logic             write;
  logic [31:0]      writedata;
  logic [31:0]      readdata;
  logic             waitrequest;
  logic [9:0][7:0]  buttonSignal;
  logic [7:0]       autoThreshold;
  logic [9:0]       selfTestFail;
  logic [9:0]       ledOutput_n;
  logic             powerOnBusy;
  logic [9:0]       touchMask;
  logic [7:0]       touchLevel;
  logic             deepSleep;
  logic [31:0]      rd;
  int               n_errors;
  int               checks_done;

  touch_led_out #(.TICK_CYCLES(4)) touch_led_out_i (
    .clk_sys(clk_sys), .reset(reset), .clkEn(1'b1), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .buttonSignal(buttonSignal), .autoThreshold(autoThreshold),
    .selfTestFail(selfTestFail), .deepSleep(deepSleep),
    .ledOutput_n(ledOutput_n), .powerOnBusy(powerOnBusy));

  touch_pad_model touch_pad_model_i (
    .touchMask(touchMask), .touchLevel(touchLevel),
    .buttonSignal(buttonSignal), .autoThreshold(autoThreshold),
    .selfTestFail(selfTestFail));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Register outputs read in the active region hold their pre-edge value
  task automatic busWr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask

  task automatic busRd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    address <= a;
    read <= 1'b1;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask

  task automatic waitOut(input int idx, input logic val);
    int k;
    k = 0;
    while (ledOutput_n[idx] !== val && k < 200) begin
      @(posedge clk_sys);
      k++;
    end
    `CHK(ledOutput_n[idx], val, "output level not reached")
  endtask

  task automatic press(input logic [9:0] m, input int settle);
    @(posedge clk_sys);
    touchMask <= m;
    repeat (settle) @(posedge clk_sys);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk_sys);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    n_errors = 0;
    checks_done = 0;
    reset = 1'b1;
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    touchMask = 10'h000;
    touchLevel = 8'h90;
    deepSleep = 1'b0;
    repeat (3) @(posedge clk_sys);
    `CHK(ledOutput_n, 10'h3FF, "outputs not idle in reset")
    `CHK(powerOnBusy, 1'b1, "busy not set in reset")
    reset <= 1'b0;
    // Touches during power-on must not register
    press(10'h001, 20);
    busWr(6'h04, 32'h0000_0080);
    busRd(6'h04, rd);
    `CHK(rd, 32'h0000_0064, "write taken while busy")
    busRd(6'h18, rd);
    `CHK(rd[9:0], 10'h000, "button live while busy")
    busRd(6'h1C, rd);
    `CHK(rd, 32'h0000_0000, "unmapped read not zero")
    press(10'h000, 1);
    while (powerOnBusy !== 1'b0) @(posedge clk_sys);
    $display("test powerup done");

    busWr(6'h04, 32'h0000_0080);
    busRd(6'h04, rd);
    `CHK(rd[7:0], 8'h80, "threshold readback")
    touchLevel <= 8'h7F;
    press(10'h001, 40);
    `CHK(ledOutput_n[0], 1'b1, "below threshold turned on")
    touchLevel <= 8'h80;
    waitOut(0, 1'b0);
    busRd(6'h18, rd);
    `CHK(rd[9:0], 10'h001, "status at threshold")
    press(10'h000, 1);
    waitOut(0, 1'b1);
    $display("test threshold done");

    busWr(6'h08, 32'h0000_0003);
    press(10'h002, 1);
    waitOut(1, 1'b0);
    press(10'h003, 40);
    busRd(6'h18, rd);
    `CHK(rd[9:0], 10'h002, "suppression kept two on")
    `CHK(ledOutput_n[0], 1'b1, "suppressed output on")
    press(10'h000, 1);
    waitOut(1, 1'b1);
    $display("test suppression done");

    busWr(6'h14, 32'h0000_0001);
    press(10'h020, 1);
    waitOut(5, 1'b0);
    press(10'h000, 9);
    `CHK(ledOutput_n[5], 1'b0, "hold ended early")
    waitOut(5, 1'b1);
    $display("test hold done");

    busWr(6'h00, 32'h0000_0020);
    press(10'h001, 1990);
    `CHK(ledOutput_n[0], 1'b0, "auto reset too early")
    repeat (19) @(posedge clk_sys);
    `CHK(ledOutput_n[0], 1'b1, "auto reset missed or held")
    press(10'h000, 8);
    $display("test auto reset done");

    busWr(6'h0C, 32'h0000_0001);
    press(10'h001, 1);
    waitOut(0, 1'b0);
    press(10'h000, 40);
    `CHK(ledOutput_n[0], 1'b0, "toggle followed release")
    press(10'h001, 1);
    waitOut(0, 1'b1);
    press(10'h000, 40);
    `CHK(ledOutput_n[0], 1'b1, "toggle state lost")
    $display("test toggle done");

    busWr(6'h30, 32'h0000_640A);
    busWr(6'h34, 32'h0101_0101);
    busRd(6'h30, rd);
    `CHK(rd, 32'h0000_640A, "effect group readback")
    busRd(6'h38, rd);
    `CHK(rd, 32'h0000_0000, "effect groups not separate")
    busWr(6'h10, 32'h0000_0010);
    press(10'h010, 40);
    `CHK(ledOutput_n[4], 1'b0, "effect left high while held")
    deepSleep <= 1'b1;
    repeat (3) @(posedge clk_sys);
    `CHK(ledOutput_n[4], 1'b1, "effect kept in deep sleep")
    deepSleep <= 1'b0;
    press(10'h000, 8);
    $display("test effects done");
    tally_and_finish();
  end
endmodule // test_touch_led_out
